// file: verilog/ebs_bus_ctrl.sv
// External memory bus strobes, port 2 address routing and eight selectable data pointers.
// Assumes the CPU core shares the clock; the access select pin is asynchronous.
`timescale 1ns/1ps

module ebs_bus_ctrl (
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	input wire logic ext_fetch_select_n_i,
	input wire logic [7:0] sfr_addr_i,
	input wire logic sfr_wr_i,
	input wire logic [7:0] sfr_wdata_i,
	output logic [7:0] sfr_rdata_o,
	input wire logic ptr_load_i,
	input wire logic [15:0] ptr_load_val_i,
	input wire logic ptr_inc_i,
	output logic [15:0] active_pointer_o,
	input wire logic [15:0] pc_i,
	input wire logic [7:0] p2_reg_i,
	input wire logic mv_req_i,
	input wire logic mv_write_i,
	input wire logic mv_use_ptr_i,
	input wire logic [7:0] mv_ri_addr_i,
	input wire logic [7:0] mv_wdata_i,
	output logic mv_done_o,
	output logic [7:0] mv_rdata_o,
	output logic fetch_valid_o,
	output logic [7:0] fetch_data_o,
	output logic addr_latch_o,
	output logic program_fetch_strobe_n_o,
	output logic rd_n_o,
	output logic wr_n_o,
	input wire logic [7:0] p0_i,
	output logic [7:0] p0_o,
	output logic p0_oe_n_o,
	output logic [7:0] p2_o,
	output logic p2_addr_mode_o,
	output logic p0_latch_set_o
);

	// ------------------------------------------------------------
	// Access select pin synchroniser.
	// ------------------------------------------------------------
	logic xfs_s1_q, xfs_s2_q, xfs_s3_q, xfs_n_q;
	logic ext_exec;

	// A change is taken once the second and third stage agree.
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			xfs_s1_q <= 1'b1;
			xfs_s2_q <= 1'b1;
			xfs_s3_q <= 1'b1;
			xfs_n_q <= 1'b1;
		end else begin
			xfs_s1_q <= ext_fetch_select_n_i;
			xfs_s2_q <= xfs_s1_q;
			xfs_s3_q <= xfs_s2_q;
			if (xfs_s2_q == xfs_s3_q) begin
				xfs_n_q <= xfs_s3_q;
			end
		end
	end

	assign ext_exec = !xfs_n_q;

	// ------------------------------------------------------------
	// Special function registers and the pointer store.
	// ------------------------------------------------------------
	logic [2:0] sel_q, sel_d;
	logic [7:0] sys_ctrl_q;
	logic wr_sel, wr_sys, wr_lo, wr_hi, ale_en;
	logic [15:0] ptr_q, ptr_wdata;
	logic [7:0] rdata_d;

	// Register decode from the core's write strobe.
	assign wr_sel = sfr_wr_i && (sfr_addr_i == ebs_pkg::PTR_SEL_ADDR);
	assign wr_sys = sfr_wr_i && (sfr_addr_i == ebs_pkg::SYS_CTRL_ADDR);
	assign wr_lo = ptr_load_i || ptr_inc_i || (sfr_wr_i && sfr_addr_i == ebs_pkg::PTR_LOW_ADDR);
	assign wr_hi = ptr_load_i || ptr_inc_i || (sfr_wr_i && sfr_addr_i == ebs_pkg::PTR_HIGH_ADDR);
	assign ptr_wdata = ptr_load_i ? ptr_load_val_i :
		ptr_inc_i ? 16'(ptr_q + 16'h0001) : {sfr_wdata_i, sfr_wdata_i};
	assign sel_d = wr_sel ? sfr_wdata_i[2:0] : sel_q;
	assign ale_en = ext_exec || sys_ctrl_q[ebs_pkg::ALE_GATE_BIT];

	// Select and control registers; only the low three select bits are kept.
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sel_q <= ebs_pkg::PTR_SEL_RST;
			sys_ctrl_q <= ebs_pkg::SYS_CTRL_RST;
		end else begin
			sel_q <= sel_d;
			if (wr_sys) begin
				sys_ctrl_q <= sfr_wdata_i & ebs_pkg::SYS_CTRL_WMASK;
			end
		end
	end

	// The read port follows the next selection so the new pointer serves the next instruction.
	ebs_ptr_mem ebs_ptr_mem_inst (
		.sys_clk_i(sys_clk_i),
		.resetn_i(resetn_i),
		.waddr_i(sel_q),
		.we_hi_i(wr_hi),
		.we_lo_i(wr_lo),
		.wdata_i(ptr_wdata),
		.raddr_i(sel_d),
		.rdata_o(ptr_q)
	);

	assign active_pointer_o = ptr_q;

	// Register read mux; unmapped addresses read zero.
	always_comb begin
		if (sfr_addr_i == ebs_pkg::PTR_SEL_ADDR) begin
			rdata_d = {5'h00, sel_q};
		end else if (sfr_addr_i == ebs_pkg::SYS_CTRL_ADDR) begin
			rdata_d = sys_ctrl_q;
		end else if (sfr_addr_i == ebs_pkg::PTR_LOW_ADDR) begin
			rdata_d = ptr_q[7:0];
		end else if (sfr_addr_i == ebs_pkg::PTR_HIGH_ADDR) begin
			rdata_d = ptr_q[15:8];
		end else begin
			rdata_d = 8'h00;
		end
	end

	// ------------------------------------------------------------
	// Bus sequencer.
	// ------------------------------------------------------------
	ebs_pkg::ebs_state_e st_q, st_d;
	logic [2:0] ph_q, ph_d;
	logic pend_q, mv_wr_q, boundary, take_mv, take_fetch;
	logic [15:0] mv_addr_q, fa_q, fa_d;
	logic [7:0] mv_wdata_q;

	// A move may start only at the end of a fetch or data cycle, or from idle.
	assign boundary = (st_q == ebs_pkg::S_IDLE) ||
		(st_q == ebs_pkg::S_FETCH && ph_q == ebs_pkg::FETCH_LAST) ||
		(st_q == ebs_pkg::S_DATA && ph_q == ebs_pkg::DATA_LAST);
	assign take_mv = boundary && (pend_q || mv_req_i);
	assign take_fetch = boundary && !take_mv && ale_en;
	assign fa_d = take_fetch ? pc_i : fa_q;

	// Next state: fetch cycles run back to back, two per six periods.
	always_comb begin
		st_d = st_q;
		ph_d = 3'(ph_q + 3'h1);
		if (take_mv) begin
			st_d = ebs_pkg::S_DATA;
			ph_d = 3'h0;
		end else if (take_fetch) begin
			st_d = ebs_pkg::S_FETCH;
			ph_d = 3'h0;
		end else if (boundary) begin
			st_d = ebs_pkg::S_IDLE;
			ph_d = 3'h0;
		end
	end

	// Request capture; a request seen at a boundary is taken at once and does not set the pending flag.
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_q <= ebs_pkg::S_IDLE;
			ph_q <= 3'h0;
			pend_q <= 1'b0;
			mv_wr_q <= 1'b0;
			mv_addr_q <= 16'h0000;
			mv_wdata_q <= 8'h00;
			fa_q <= 16'h0000;
		end else begin
			st_q <= st_d;
			ph_q <= ph_d;
			fa_q <= fa_d;
			pend_q <= (pend_q && !take_mv) || (mv_req_i && !boundary);
			if (mv_req_i) begin
				mv_wr_q <= mv_write_i;
				mv_addr_q <= mv_use_ptr_i ? ptr_q : {p2_reg_i, mv_ri_addr_i};
				mv_wdata_q <= mv_wdata_i;
			end
		end
	end

	// ------------------------------------------------------------
	// Registered pin drivers, computed from the next state.
	// ------------------------------------------------------------
	logic ext_fetch_d, data_d, strobe_win, drive_addr, drive_data;
	logic [15:0] mv_addr_d;

	assign mv_addr_d = mv_req_i ? (mv_use_ptr_i ? ptr_q : {p2_reg_i, mv_ri_addr_i}) : mv_addr_q;
	assign ext_fetch_d = (st_d == ebs_pkg::S_FETCH) && ext_exec;
	assign data_d = (st_d == ebs_pkg::S_DATA);
	assign strobe_win = data_d && ph_d >= ebs_pkg::STROBE_FIRST && ph_d < ebs_pkg::DATA_LAST;
	assign drive_addr = (ext_fetch_d || data_d) && ph_d == 3'h0;
	assign drive_data = data_d && (mv_req_i ? mv_write_i : mv_wr_q) && ph_d != 3'h0;

	// Strobes and port drive follow the sequencer phase.
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			addr_latch_o <= 1'b0;
			program_fetch_strobe_n_o <= 1'b1;
			rd_n_o <= 1'b1;
			wr_n_o <= 1'b1;
			p0_o <= 8'h00;
			p0_oe_n_o <= 1'b1;
			p2_o <= 8'h00;
			p2_addr_mode_o <= 1'b0;
			p0_latch_set_o <= 1'b0;
		end else begin
			addr_latch_o <= (st_d != ebs_pkg::S_IDLE) && ph_d == 3'h0;
			program_fetch_strobe_n_o <= !(ext_fetch_d && ph_d != 3'h0);
			rd_n_o <= !(strobe_win && !(mv_req_i ? mv_write_i : mv_wr_q));
			wr_n_o <= !(strobe_win && (mv_req_i ? mv_write_i : mv_wr_q));
			p0_o <= drive_addr ? (data_d ? mv_addr_d[7:0] : fa_d[7:0]) :
				(mv_req_i ? mv_wdata_i : mv_wdata_q);
			p0_oe_n_o <= !(drive_addr || drive_data);
			p2_o <= ext_fetch_d ? fa_d[15:8] : data_d ? mv_addr_d[15:8] : p2_reg_i;
			p2_addr_mode_o <= ext_exec;
			p0_latch_set_o <= drive_addr;
		end
	end

	// Read data capture while the strobe is still active on the pins.
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sfr_rdata_o <= 8'h00;
			fetch_data_o <= 8'h00;
			fetch_valid_o <= 1'b0;
			mv_rdata_o <= 8'h00;
			mv_done_o <= 1'b0;
		end else begin
			sfr_rdata_o <= rdata_d;
			fetch_valid_o <= !program_fetch_strobe_n_o && ph_q == ebs_pkg::FETCH_LAST;
			if (!program_fetch_strobe_n_o && ph_q == ebs_pkg::FETCH_LAST) begin
				fetch_data_o <= p0_i;
			end
			if (st_q == ebs_pkg::S_DATA && !mv_wr_q && ph_q == ebs_pkg::DATA_SAMPLE) begin
				mv_rdata_o <= p0_i;
			end
			mv_done_o <= st_q == ebs_pkg::S_DATA && ph_q == ebs_pkg::DATA_LAST;
		end
	end

	// ------------------------------------------------------------
	// Assertions.
	// ------------------------------------------------------------
	sequence fetch_strobe_seq;
		!program_fetch_strobe_n_o [*2] ##1 program_fetch_strobe_n_o;
	endsequence
	sequence read_strobe_seq;
		!rd_n_o [*3] ##1 rd_n_o;
	endsequence
	a_fetch_three_periods: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
		addr_latch_o && st_q == ebs_pkg::S_FETCH && ext_exec && $past(ext_exec)
		|-> ##1 fetch_strobe_seq) else $error("fetch cycle is not three periods");
	a_read_six_periods: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
		$fell(rd_n_o) |-> $past(addr_latch_o, 2) ##0 read_strobe_seq ##1 mv_done_o)
		else $error("data read cycle is not six periods");
	a_internal_no_strobe: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
		xfs_n_q && $past(xfs_n_q) |-> program_fetch_strobe_n_o)
		else $error("fetch strobe active during internal execution");
	a_gated_latch_only: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
		addr_latch_o && $past(xfs_n_q) && !$past(sys_ctrl_q[ebs_pkg::ALE_GATE_BIT])
		|-> st_q == ebs_pkg::S_DATA) else $error("address latch outside a data move");
	a_ext_always_latch: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
		ext_exec && $past(ext_exec) |-> st_q != ebs_pkg::S_IDLE)
		else $error("bus idle during external execution");
	a_port2_pointer_high: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
		st_q == ebs_pkg::S_DATA && $stable(mv_addr_q) |-> p2_o == mv_addr_q[15:8])
		else $error("port 2 not showing move address high byte");
	a_select_update: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
		wr_sel |=> sel_q == $past(sfr_wdata_i[2:0]) && sfr_rdata_o[7:3] == 5'h00)
		else $error("pointer select not updated");
	a_pointer_increment: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
		ptr_inc_i && !ptr_load_i && !sfr_wr_i |=> ptr_q == 16'($past(ptr_q) + 16'h0001))
		else $error("selected pointer not incremented");
	a_latch_all_ones: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
		addr_latch_o && ($past(ext_exec) || st_q == ebs_pkg::S_DATA) |-> p0_latch_set_o)
		else $error("port 0 latch not set on external access");
	a_port0_driven: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
		!wr_n_o |-> !p0_oe_n_o) else $error("port 0 released during write strobe");
endmodule // ebs_bus_ctrl

// file: pkg/ebs_pkg.sv
// Shared constants of the external bus strobe and pointer select block.
// Assumes one 250 MHz clock where one clock period is one oscillator period.
package ebs_pkg;

	// ------------------------------------------------------------
	// Register addresses in the special function register space.
	// ------------------------------------------------------------
	localparam logic [7:0] PTR_SEL_ADDR = 8'h92;
	localparam logic [7:0] SYS_CTRL_ADDR = 8'hb1;
	localparam logic [7:0] PTR_LOW_ADDR = 8'h82;
	localparam logic [7:0] PTR_HIGH_ADDR = 8'h83;

	// ------------------------------------------------------------
	// Field layout and reset values.
	// ------------------------------------------------------------
	localparam int PTR_SEL_W = 3;
	localparam int PTR_NUM = 8;
	localparam int PTR_W = 16;
	localparam int ALE_GATE_BIT = 5;
	localparam logic [7:0] SYS_CTRL_RST = 8'h21;
	localparam logic [7:0] SYS_CTRL_WMASK = 8'h73;
	localparam logic [2:0] PTR_SEL_RST = 3'h0;

	// ------------------------------------------------------------
	// Cycle timing in oscillator periods.
	// ------------------------------------------------------------
	localparam int OSC_NS = 4;
	localparam int FETCH_PERIODS = 3;
	localparam int DATA_PERIODS = 6;
	localparam logic [2:0] FETCH_LAST = 3'(FETCH_PERIODS - 1);
	localparam logic [2:0] DATA_LAST = 3'(DATA_PERIODS - 1);
	localparam logic [2:0] STROBE_FIRST = 3'h2;
	localparam logic [2:0] DATA_SAMPLE = 3'h4;
	localparam logic [7:0] P0_LATCH_ALL_ONES = 8'hff;

	// Bus sequencer states.
	typedef enum logic [1:0] {
		S_IDLE,
		S_FETCH,
		S_DATA
	} ebs_state_e;

endpackage

// file: verilog/ebs_ptr_mem.sv
// Eight-entry store of 16-bit data pointers with a registered read port.
// Assumes writer and reader share the clock; a write to the read index is forwarded.
`timescale 1ns/1ps

module ebs_ptr_mem (
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	input wire logic [2:0] waddr_i,
	input wire logic we_hi_i,
	input wire logic we_lo_i,
	input wire logic [15:0] wdata_i,
	input wire logic [2:0] raddr_i,
	output logic [15:0] rdata_o
);

	logic [15:0] mem_q [0:7];
	logic [15:0] merged;

	// Merge the byte lanes being written into the addressed word.
	assign merged = {we_hi_i ? wdata_i[15:8] : mem_q[waddr_i][15:8],
		we_lo_i ? wdata_i[7:0] : mem_q[waddr_i][7:0]};

	// Only the addressed entry changes; the other seven keep their value.
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			for (int i = 0; i < 8; i++) begin
				mem_q[i] <= 16'h0000;
			end
		end else if (we_hi_i || we_lo_i) begin
			mem_q[waddr_i] <= merged;
		end
	end

	// Read data is registered; a same-cycle write to the read index is passed through.
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rdata_o <= 16'h0000;
		end else if ((we_hi_i || we_lo_i) && (waddr_i == raddr_i)) begin
			rdata_o <= merged;
		end else begin
			rdata_o <= mem_q[raddr_i];
		end
	end

endmodule // ebs_ptr_mem

// file: testbench/ebs_ext_mem.sv
// External program and data memory model on the multiplexed port 0 bus.
// Assumes the bus controller's registered strobes; pins are resolved here.
`timescale 1ns/1ps

module ebs_ext_mem (
	input wire logic sys_clk_i,
	input wire logic addr_latch_i,
	input wire logic [7:0] p0_drv_i,
	input wire logic p0_oe_n_i,
	input wire logic fetch_n_i,
	input wire logic rd_n_i,
	input wire logic wr_n_i,
	output logic [7:0] p0_pin_o
);
	logic [7:0] mem [0:255];
	logic [7:0] adr_q;
	logic [7:0] last_q;
	logic read_n;

	// One shared memory serves code and data, read by the ANDed strobes.
	assign read_n = fetch_n_i & rd_n_i;

	// Memory starts with a known pattern so reads can be predicted.
	initial begin
		for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'ha5;
	end

	// Latch the low address, store writes and remember the last pin level.
	always @(posedge sys_clk_i) begin
		if (addr_latch_i) adr_q <= p0_drv_i;
		if (!wr_n_i && !p0_oe_n_i) mem[adr_q] <= p0_drv_i;
		last_q <= p0_pin_o;
	end

	// A released bus toggles, so a stale value is never mistaken for data.
	assign p0_pin_o = !p0_oe_n_i ? p0_drv_i : (!read_n ? mem[adr_q] : ~last_q);
endmodule // ebs_ext_mem

// file: testbench/test_ext_bus_strobes_and_pointer_select.sv
// Self-checking bench for the external bus strobe and pointer select block.
// Assumes the external memory model answers on port 0.
`timescale 1ns/1ps

module test_ext_bus_strobes_and_pointer_select;
	logic clk = 1'b0, rstn = 1'b0, xfs_n = 1'b1, wr = 1'b0, ld = 1'b0, inc = 1'b0;
	logic req = 1'b0, mw = 1'b0, mp = 1'b0;
	logic [7:0] addr = 8'h00, wd = 8'h00, ri = 8'h00, mwd = 8'h00;
	logic [15:0] ldv = 16'h0000;
	logic [7:0] rdata, mrd, fd, p0i, p0o, p2;
	logic [15:0] ap;
	logic done, fv, ale, ps_n, rd_n, wr_n, oe_n, p2m, p0set;
	int error_cnt = 0, n_checks = 0, n_ale, n_ps, k;

	ebs_bus_ctrl ebs_bus_ctrl_inst (.sys_clk_i(clk), .resetn_i(rstn),
		.ext_fetch_select_n_i(xfs_n), .sfr_addr_i(addr), .sfr_wr_i(wr), .sfr_wdata_i(wd),
		.sfr_rdata_o(rdata), .ptr_load_i(ld), .ptr_load_val_i(ldv), .ptr_inc_i(inc),
		.active_pointer_o(ap), .pc_i(16'h3c17), .p2_reg_i(8'h77), .mv_req_i(req),
		.mv_write_i(mw), .mv_use_ptr_i(mp), .mv_ri_addr_i(ri), .mv_wdata_i(mwd),
		.mv_done_o(done), .mv_rdata_o(mrd), .fetch_valid_o(fv), .fetch_data_o(fd),
		.addr_latch_o(ale), .program_fetch_strobe_n_o(ps_n), .rd_n_o(rd_n), .wr_n_o(wr_n),
		.p0_i(p0i), .p0_o(p0o), .p0_oe_n_o(oe_n), .p2_o(p2), .p2_addr_mode_o(p2m),
		.p0_latch_set_o(p0set));

	ebs_ext_mem ebs_ext_mem_inst (.sys_clk_i(clk), .addr_latch_i(ale), .p0_drv_i(p0o),
		.p0_oe_n_i(oe_n), .fetch_n_i(ps_n), .rd_n_i(rd_n), .wr_n_i(wr_n), .p0_pin_o(p0i));

	// Free-running 4 ns clock.
	initial begin
		forever #2 clk = ~clk;
	end

	// Compares one value and counts the outcome.
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Prints the counts and the verdict, then stops.
	task automatic conclude();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	// Register write and registered read, one strobe cycle each.
	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		wd = d;
		wr = 1'b1;
		@(negedge clk);
		wr = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge clk);
		addr = a;
		@(negedge clk);
		chk(rdata, e);
	endtask

	// Counts latch and fetch strobe cycles over a window.
	task automatic watch(input int n);
		n_ale = 0;
		n_ps = 0;
		repeat (n) begin
			@(negedge clk);
			if (ale === 1'b1) n_ale++;
			if (ps_n === 1'b0) n_ps++;
		end
	endtask

	// One data move: address phase, strobe length and cycle span are checked.
	task automatic mv(input logic w, input logic p, input logic [7:0] d, ep2, ep0);
		int n, rds, pss;
		@(negedge clk);
		req = 1'b1;
		mw = w;
		mp = p;
		mwd = d;
		ri = ep0;
		@(negedge clk);
		req = 1'b0;
		k = 0;
		n = 0;
		rds = 0;
		pss = 0;
		while (!(ale === 1'b1 && p2 === ep2) && k < 12) begin
			@(negedge clk);
			k++;
		end
		chk(p0o, ep0);
		chk(oe_n, 1'b0);
		chk(p0set, 1'b1);
		chk(p2, ep2);
		while (done !== 1'b1 && n < 12) begin
			@(negedge clk);
			n++;
			if ((w ? wr_n : rd_n) === 1'b0) rds++;
			if (ps_n === 1'b0) pss++;
		end
		chk(16'(n), 16'd6);
		chk(16'(rds), 16'd3);
		chk(16'(pss), 16'd0);
	endtask

	// Cuts a hang short.
	initial begin
		#40000;
		error_cnt++;
		conclude();
	end

	// Main sequence.
	initial begin
		repeat (5) @(negedge clk);
		rstn = 1'b1;
		rd(8'hb1, 8'h21);
		rd(8'h92, 8'h00);
		rd(8'h90, 8'h00);
		chk(p2m, 1'b0);
		wreg(8'hb1, 8'hff);
		rd(8'hb1, 8'h73);
		watch(30);
		chk(16'(n_ps), 16'd0);
		chk(16'(n_ale), 16'd10);
		wreg(8'hb1, 8'h01);
		watch(30);
		chk(16'(n_ale), 16'd0);
		for (int i = 0; i < 8; i++) begin
			wreg(8'h92, 8'(i) | 8'hf8);
			wreg(8'h82, 8'(i * 16 + 1));
			wreg(8'h83, 8'(i) ^ 8'hc0);
		end
		for (int i = 0; i < 8; i++) begin
			wreg(8'h92, 8'(i));
			chk(ap, {8'(i) ^ 8'hc0, 8'(i * 16 + 1)});
			rd(8'h92, 8'(i));
			rd(8'h83, 8'(i) ^ 8'hc0);
		end
		wreg(8'h92, 8'h03);
		@(negedge clk);
		ldv = 16'h12ff;
		ld = 1'b1;
		@(negedge clk);
		ld = 1'b0;
		inc = 1'b1;
		@(negedge clk);
		inc = 1'b0;
		@(negedge clk);
		chk(ap, 16'h1300);
		wreg(8'h92, 8'h02);
		@(negedge clk);
		chk(ap, 16'hc221);
		mv(1'b1, 1'b1, 8'h9e, 8'hc2, 8'h21);
		mv(1'b0, 1'b1, 8'h00, 8'hc2, 8'h21);
		chk(mrd, 8'h9e);
		mv(1'b0, 1'b0, 8'h00, 8'h77, 8'h44);
		chk(mrd, 8'h44 ^ 8'ha5);
		xfs_n = 1'b0;
		repeat (10) @(negedge clk);
		watch(30);
		chk(16'(n_ale), 16'd10);
		chk(16'(n_ps), 16'd20);
		chk(p2m, 1'b1);
		k = 0;
		while (fv !== 1'b1 && k < 12) begin
			@(negedge clk);
			k++;
		end
		chk(fd, 8'h17 ^ 8'ha5);
		k = 0;
		while (ale !== 1'b1 && k < 12) begin
			@(negedge clk);
			k++;
		end
		chk(p2, 8'h3c);
		chk(p0o, 8'h17);
		mv(1'b0, 1'b1, 8'h00, 8'hc2, 8'h21);
		chk(mrd, 8'h9e);
		conclude();
	end
endmodule // test_ext_bus_strobes_and_pointer_select
